// *** shared/bws_pkg.sv ***
// Package: register map, field layout and decode types for the bridge window/status block
package bws_pkg;
   // Register offsets (byte addresses)
   localparam logic [7:0]  OFS_STATUS_IO   = 8'h1c;
   localparam logic [7:0]  OFS_MEM_WINDOW  = 8'h20;
   localparam logic [7:0]  OFS_EVT_STATUS  = 8'h40;
   localparam logic [7:0]  OFS_EVT_MASK    = 8'h44;
   // Status/io register field positions
   localparam int          BIT_ABORT_SENT  = 27;
   localparam int          SEL_TIMING_LO   = 25;
   localparam int          BIT_PARITY_SEEN = 24;
   localparam int          BIT_FAST_CONSEC = 23;
   localparam int          BIT_HIGH_CLOCK  = 21;
   localparam int          IO_CEIL_LO      = 12;
   localparam int          IO_CEIL_W_LO    = 8;
   localparam int          IO_FLOOR_LO     = 4;
   localparam int          IO_FLOOR_W_LO   = 0;
   // Memory window field positions
   localparam int          MEM_CEIL_LO     = 20;
   localparam int          MEM_FLOOR_LO    = 4;
   // Fixed field values
   localparam logic [1:0]  SEL_TIMING_MED  = 2'h1;
   localparam logic [3:0]  IO_WIDTH_32     = 4'h1;
   localparam logic [11:0] IO_LOW_ONES     = 12'hfff;
   localparam logic [11:0] IO_LOW_ZERO     = 12'h000;
   localparam logic [19:0] MEM_LOW_ONES    = 20'hfffff;
   localparam logic [19:0] MEM_LOW_ZERO    = 20'h00000;
   // Event bits in status/mask registers
   localparam int          EVT_ABORT       = 0;
   localparam int          EVT_PARITY      = 1;
   localparam int          EVT_W           = 2;
   // Transaction presented for a forwarding decision
   typedef struct packed {
      logic        valid;
      logic        isIo;
      logic [31:0] addr;
   } bws_txn_t;
endpackage

// *** hdl/bws_window_cmp.sv ***
// Inclusive window compare with disable on inverted bounds
module bws_window_cmp #(
   parameter int W = 32
) (
   // Window bounds
   input  wire logic [W-1:0] floorAddr,
   input  wire logic [W-1:0] ceilAddr,
   // Address under test
   input  wire logic [W-1:0] addr,
   // Result
   output logic              hit
);
   // Inverted bounds mean disabled; range check plus an explicit floorAddr <= ceilAddr term
   always_comb
   begin
      hit = (addr >= floorAddr) && (addr <= ceilAddr) && (floorAddr <= ceilAddr);
   end
endmodule

// *** hdl/bridge_window_status_regs.sv ***
// Bridge secondary status, I/O window and memory window registers with forward decode
//
// Behaviour
// - Target abort as responder sets abort bit; write one clears; resets zero.
// - Select-timing field reads fixed 01; writes ignored.
// - Uncorrectable data error sets parity bit; write one clears; resets zero.
// - Fast consecutive capability reads constant one.
// - High clock capability reads constant one.
// - Four-bit I/O ceiling field gives bound bits 15:12, low bits all ones.
// - Four-bit I/O floor field in 7:4 gives bits 15:12, low bits zero.
// - Both I/O width code nibbles read 0x1.
// - Forward I/O transactions whose address is inside the I/O window.
// - Twelve-bit memory ceiling in 31:20, low twenty bits all ones.
// - Twelve-bit memory floor in 15:4, low twenty bits zero.
// - Forward memory transactions inside the inclusive memory window.
//
// Implementation choice: the strobed register port.
module bridge_window_status_regs (
   // Clock and reset
   input  wire logic              sys_clk,
   input  wire logic              rst,
   // Register port
   input  wire logic [7:0]        regAddr,
   input  wire logic [31:0]       regWrData,
   input  wire logic              regWrEn,
   input  wire logic              regRdEn,
   output logic      [31:0]       regRdData,
   // Events from the bus side logic (same clock)
   input  wire logic              abortSentEvt,
   input  wire logic              parityErrEvt,
   // Transaction to decide on
   input  wire bws_pkg::bws_txn_t txnIn,
   output logic                   txnForward,
   output logic                   txnValidOut,
   // Interrupt
   output logic                   irq
);
   // State
   logic       abortSent_q, abortSent_d;
   logic       paritySeen_q, paritySeen_d;
   logic [3:0] ioCeil_q, ioCeil_d;
   logic [3:0] ioFloor_q, ioFloor_d;
   logic [11:0] memCeil_q, memCeil_d;
   logic [11:0] memFloor_q, memFloor_d;
   logic [bws_pkg::EVT_W-1:0] evtSts_q, evtSts_d;
   logic [bws_pkg::EVT_W-1:0] evtMask_q, evtMask_d;
   logic [31:0] rdData_d;
   logic        fwd_d, txnValid_d, irq_d;
   logic [31:0] statusWord, memWord;
   logic [15:0] ioFloorAddr, ioCeilAddr;
   logic [31:0] memFloorAddr, memCeilAddr;
   logic        ioHit, memHit;
   logic        wrStatus, wrMem, wrEvt, wrMask;

   // Write strobes per register
   assign wrStatus = regWrEn && (regAddr == bws_pkg::OFS_STATUS_IO);
   assign wrMem    = regWrEn && (regAddr == bws_pkg::OFS_MEM_WINDOW);
   assign wrEvt    = regWrEn && (regAddr == bws_pkg::OFS_EVT_STATUS);
   assign wrMask   = regWrEn && (regAddr == bws_pkg::OFS_EVT_MASK);

   // Read view of status/io register; unlisted bits stay zero
   always_comb
   begin
      statusWord = 32'h0000_0000;
      statusWord[bws_pkg::BIT_ABORT_SENT] = abortSent_q;
      statusWord[bws_pkg::SEL_TIMING_LO +: 2] = bws_pkg::SEL_TIMING_MED;
      statusWord[bws_pkg::BIT_PARITY_SEEN] = paritySeen_q;
      statusWord[bws_pkg::BIT_FAST_CONSEC] = 1'b1;
      statusWord[bws_pkg::BIT_HIGH_CLOCK] = 1'b1;
      statusWord[bws_pkg::IO_CEIL_LO +: 4] = ioCeil_q;
      statusWord[bws_pkg::IO_CEIL_W_LO +: 4] = bws_pkg::IO_WIDTH_32;
      statusWord[bws_pkg::IO_FLOOR_W_LO +: 4] = bws_pkg::IO_WIDTH_32;
      statusWord[bws_pkg::IO_FLOOR_LO +: 4] = ioFloor_q;
   end

   // Memory window read view; reserved nibbles read zero
   always_comb
   begin
      memWord = 32'h0000_0000;
      memWord[bws_pkg::MEM_CEIL_LO +: 12] = memCeil_q;
      memWord[bws_pkg::MEM_FLOOR_LO +: 12] = memFloor_q;
   end

   // Full window bounds from the programmed fields
   always_comb
   begin
      ioCeilAddr   = {ioCeil_q, bws_pkg::IO_LOW_ONES};
      ioFloorAddr  = {ioFloor_q, bws_pkg::IO_LOW_ZERO};
      memCeilAddr  = {memCeil_q, bws_pkg::MEM_LOW_ONES};
      memFloorAddr = {memFloor_q, bws_pkg::MEM_LOW_ZERO};
   end

   // I/O window compare on 16-bit I/O space; upper address bits must be zero
   bws_window_cmp #(
      .W (16)
   ) uIoCmp (
      .floorAddr (ioFloorAddr),
      .ceilAddr  (ioCeilAddr),
      .addr      (txnIn.addr[15:0]),
      .hit       (ioHit)
   );

   // Memory window compare
   bws_window_cmp #(
      .W (32)
   ) uMemCmp (
      .floorAddr (memFloorAddr),
      .ceilAddr  (memCeilAddr),
      .addr      (txnIn.addr),
      .hit       (memHit)
   );

   // Next state of status, window and interrupt registers
   always_comb
   begin
      abortSent_d  = abortSent_q;
      paritySeen_d = paritySeen_q;
      ioCeil_d     = ioCeil_q;
      ioFloor_d    = ioFloor_q;
      memCeil_d    = memCeil_q;
      memFloor_d   = memFloor_q;
      evtSts_d     = evtSts_q;
      evtMask_d    = evtMask_q;
      if (wrStatus && regWrData[bws_pkg::BIT_ABORT_SENT])
      begin
         abortSent_d = 1'b0;
      end
      if (abortSentEvt)
      begin
         abortSent_d = 1'b1;
      end
      if (wrStatus && regWrData[bws_pkg::BIT_PARITY_SEEN])
      begin
         paritySeen_d = 1'b0;
      end
      if (parityErrEvt)
      begin
         paritySeen_d = 1'b1;
      end
      if (wrStatus)
      begin
         ioCeil_d  = regWrData[bws_pkg::IO_CEIL_LO +: 4];
         ioFloor_d = regWrData[bws_pkg::IO_FLOOR_LO +: 4];
      end
      if (wrMem)
      begin
         memCeil_d  = regWrData[bws_pkg::MEM_CEIL_LO +: 12];
         memFloor_d = regWrData[bws_pkg::MEM_FLOOR_LO +: 12];
      end
      // Interrupt status: clear by one, events win
      if (wrEvt)
      begin
         evtSts_d = evtSts_q & ~regWrData[bws_pkg::EVT_W-1:0];
      end
      if (abortSentEvt)
      begin
         evtSts_d[bws_pkg::EVT_ABORT] = 1'b1;
      end
      if (parityErrEvt)
      begin
         evtSts_d[bws_pkg::EVT_PARITY] = 1'b1;
      end
      if (wrMask)
      begin
         evtMask_d = regWrData[bws_pkg::EVT_W-1:0];
      end
   end

   // Output next values: read mux, forward decision, interrupt level
   always_comb
   begin
      rdData_d = 32'h0000_0000;
      if (regRdEn)
      begin
         case (regAddr)
            bws_pkg::OFS_STATUS_IO:  rdData_d = statusWord;
            bws_pkg::OFS_MEM_WINDOW: rdData_d = memWord;
            bws_pkg::OFS_EVT_STATUS: rdData_d = {30'h0, evtSts_q};
            bws_pkg::OFS_EVT_MASK:   rdData_d = {30'h0, evtMask_q};
            default:                 rdData_d = 32'h0000_0000; // Unmapped reads zero
         endcase
      end
      fwd_d = txnIn.valid && (txnIn.isIo ? (ioHit && (txnIn.addr[31:16] == 16'h0000)) : memHit);
      txnValid_d = txnIn.valid;
      irq_d = |(evtSts_d & evtMask_d);
   end

   // Register everything; outputs leave straight from flops
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         abortSent_q  <= 1'b0;
         paritySeen_q <= 1'b0;
         ioCeil_q     <= 4'h0;
         ioFloor_q    <= 4'h0;
         memCeil_q    <= 12'h000;
         memFloor_q   <= 12'h000;
         evtSts_q     <= '0;
         evtMask_q    <= '0;
         regRdData    <= 32'h0000_0000;
         txnForward   <= 1'b0;
         txnValidOut  <= 1'b0;
         irq          <= 1'b0;
      end
      else
      begin
         abortSent_q  <= abortSent_d;
         paritySeen_q <= paritySeen_d;
         ioCeil_q     <= ioCeil_d;
         ioFloor_q    <= ioFloor_d;
         memCeil_q    <= memCeil_d;
         memFloor_q   <= memFloor_d;
         evtSts_q     <= evtSts_d;
         evtMask_q    <= evtMask_d;
         regRdData    <= rdData_d;
         txnForward   <= fwd_d;
         txnValidOut  <= txnValid_d;
         irq          <= irq_d;
      end
   end

   // Assertions
   AST_ABORT_SET: assert property (@(posedge sys_clk) disable iff (rst)
      abortSentEvt |=> abortSent_q) else $error("abort bit not set");
   AST_ABORT_CLR: assert property (@(posedge sys_clk) disable iff (rst)
      (wrStatus && regWrData[bws_pkg::BIT_ABORT_SENT] && !abortSentEvt) |=> !abortSent_q)
      else $error("abort bit not cleared");
   AST_PARITY_SET: assert property (@(posedge sys_clk) disable iff (rst)
      parityErrEvt |=> paritySeen_q) else $error("parity bit not set");
   AST_CONST_READ: assert property (@(posedge sys_clk) disable iff (rst)
      (regRdEn && regAddr == bws_pkg::OFS_STATUS_IO) |=> (regRdData[26:25] == 2'h1 && regRdData[23]
      && regRdData[21] && regRdData[11:8] == 4'h1 && regRdData[3:0] == 4'h1))
      else $error("fixed status fields wrong");
   AST_RSVD_ZERO: assert property (@(posedge sys_clk) disable iff (rst)
      (regRdEn && regAddr == bws_pkg::OFS_MEM_WINDOW) |=> (regRdData[19:16] == 4'h0 && regRdData[3:0] == 4'h0))
      else $error("reserved bits nonzero");
   AST_MEM_WRITE: assert property (@(posedge sys_clk) disable iff (rst)
      wrMem |=> (memCeil_q == $past(regWrData[31:20]) && memFloor_q == $past(regWrData[15:4])))
      else $error("memory window not written");
   AST_IO_FWD: assert property (@(posedge sys_clk) disable iff (rst)
      (txnIn.valid && txnIn.isIo && txnIn.addr[31:16] == 16'h0000 && txnIn.addr[15:12] >= ioFloor_q
      && txnIn.addr[15:12] <= ioCeil_q && !wrStatus) |=> txnForward)
      else $error("io transaction not forwarded");
   AST_DISABLED: assert property (@(posedge sys_clk) disable iff (rst)
      (txnIn.valid && !txnIn.isIo && memFloor_q > memCeil_q) |=> !txnForward)
      else $error("disabled memory window forwarded");
   AST_IRQ: assert property (@(posedge sys_clk) disable iff (rst)
      (parityErrEvt && evtMask_q[bws_pkg::EVT_PARITY] && !wrMask) |=> irq)
      else $error("interrupt missing");

   // Main scenario coverage
   COV_IO_FWD: cover property (@(posedge sys_clk) txnIn.valid && txnIn.isIo ##1 txnForward);
   COV_MEM_FWD: cover property (@(posedge sys_clk) txnIn.valid && !txnIn.isIo ##1 txnForward);
   COV_SET_CLR: cover property (@(posedge sys_clk) abortSentEvt && wrStatus);
   COV_IRQ: cover property (@(posedge sys_clk) !irq ##1 irq);
endmodule

// *** tb/bws_bus_agent.sv ***
// Far-side bus agent model: raises error events and presents transactions
module bws_bus_agent (
   // Clock
   input  wire logic          sys_clk,
   // Events and transaction toward the block
   output logic               abortSentEvt,
   output logic               parityErrEvt,
   output bws_pkg::bws_txn_t  txnIn
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================
   // Stimulus
   initial
   begin
      abortSentEvt = 1'b0;
      parityErrEvt = 1'b0;
      txnIn        = '0;
   end
   // Error events, seen by the block at the next edge
   task automatic evt(input logic ab, input logic pe);
      @(posedge sys_clk);
      abortSentEvt <= ab;
      parityErrEvt <= pe;
   endtask
   // One transaction per call; calls may run every cycle
   task automatic txn(input logic io, input logic [31:0] ad);
      @(posedge sys_clk);
      txnIn <= '{valid: 1'b1, isIo: io, addr: ad};
   endtask
   // Released bus shows inverted junk, not the last request
   task automatic idle();
      @(posedge sys_clk);
      abortSentEvt <= 1'b0;
      parityErrEvt <= 1'b0;
      txnIn        <= '{valid: 1'b0, isIo: ~txnIn.isIo, addr: ~txnIn.addr};
   endtask
endmodule

// *** tb/tb.sv ***
// Self-checking testbench for the bridge window and status registers
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================
   // Signals
   logic              sys_clk, rst, regWrEn, regRdEn, rdPend, io;
   logic              txnForward, txnValidOut, irq, abortSentEvt, parityErrEvt;
   logic [7:0]        regAddr;
   logic [31:0]       regWrData, regRdData, ad;
   logic [3:0]        fl, cl;
   logic [11:0]       mf, mc;
   bws_pkg::bws_txn_t txnIn;
   int                n_errors, tests_run, cyc;
   logic [31:0]       rdQ[$];
   logic              fwdQ[$];

   bridge_window_status_regs dut (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
      .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .abortSentEvt(abortSentEvt),
      .parityErrEvt(parityErrEvt), .txnIn(txnIn), .txnForward(txnForward), .txnValidOut(txnValidOut), .irq(irq));
   bws_bus_agent agent (.sys_clk(sys_clk), .abortSentEvt(abortSentEvt), .parityErrEvt(parityErrEvt), .txnIn(txnIn));

   // ==========================================
   // Clock, timeout and reporting
   initial sys_clk = 1'b0;
   always #12.5 sys_clk = ~sys_clk;
   // Whole run needs a few hundred cycles
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         n_errors++;
         results();
      end
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic results();
      $display("Checks %0d, errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // ==========================================
   // Register bus master; each strobe stands one cycle and drops at its sampling edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      regAddr   <= a;
      regWrData <= d;
      regWrEn   <= 1'b1;
      regRdEn   <= 1'b0;
      @(posedge sys_clk);
      regWrEn   <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge sys_clk);
      rdQ.push_back(e);
      regAddr   <= a;
      regWrData <= $urandom;
      regRdEn   <= 1'b1;
      regWrEn   <= 1'b0;
      @(posedge sys_clk);
      regRdEn   <= 1'b0;
   endtask
   // Idle cycles, ending off the edge so direct checks see settled outputs
   task automatic idle(input int n);
      repeat (n) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask
   // Expected decision from the programmed bounds
   function automatic logic hitExp(input logic i, input logic [31:0] a);
      if (i)
         return a[31:16] == 16'h0 && a[15:0] >= {fl, 12'h000} && a[15:0] <= {cl, 12'hfff};
      return a >= {mf, 20'h00000} && a <= {mc, 20'hfffff};
   endfunction

   // ==========================================
   // Output watcher: read data stands only the cycle after the strobe
   always @(posedge sys_clk) rdPend <= regRdEn & ~rst;
   always @(negedge sys_clk)
   begin
      if (rdPend)
         check("regRdData", regRdData, rdQ.size() > 0 ? rdQ.pop_front() : 32'hx);
      else if (!rst)
         check("regRdData idle", regRdData, 32'h0);
      if (txnValidOut === 1'b1)
         check("txnForward", {31'h0, txnForward}, {31'h0, fwdQ.size() > 0 ? fwdQ.pop_front() : 1'bx});
   end

   // ==========================================
   // Main sequence
   initial
   begin
      {rst, regAddr, regWrData, regWrEn, regRdEn} = {1'b1, 42'h0};
      {n_errors, tests_run, cyc} = '0;
      void'($urandom(32'he4ce2c0a));
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      // Reset values, fixed fields and an unmapped place
      rd(bws_pkg::OFS_STATUS_IO, 32'h02a0_0101);
      rd(bws_pkg::OFS_MEM_WINDOW, 32'h0);
      rd(8'h08, 32'h0);
      agent.evt(1'b1, 1'b1);
      agent.idle();
      wr(bws_pkg::OFS_EVT_MASK, 32'h0);
      idle(3);
      check("irq masked", {31'h0, irq}, 32'h0);
      rd(bws_pkg::OFS_STATUS_IO, 32'h0ba0_0101);
      rd(bws_pkg::OFS_EVT_STATUS, 32'h3);
      wr(bws_pkg::OFS_EVT_MASK, 32'h2);
      idle(3);
      check("irq set", {31'h0, irq}, 32'h1);
      wr(bws_pkg::OFS_EVT_STATUS, 32'h2);
      idle(3);
      check("irq cleared", {31'h0, irq}, 32'h0);
      rd(bws_pkg::OFS_EVT_STATUS, 32'h1);
      // Event in the same cycle as its clearing write: the set wins
      fork
         begin
            agent.evt(1'b0, 1'b1);
            agent.idle();
         end
         wr(bws_pkg::OFS_EVT_STATUS, 32'h2);
      join
      idle(1);
      check("irq set wins", {31'h0, irq}, 32'h1);
      fork
         begin
            agent.evt(1'b1, 1'b0);
            agent.idle();
         end
         wr(bws_pkg::OFS_STATUS_IO, 32'h0900_0000);
      join
      rd(bws_pkg::OFS_STATUS_IO, 32'h0aa0_0101);
      rd(bws_pkg::OFS_EVT_STATUS, 32'h3);
      // All ones: sticky bits clear, read-only and reserved bits hold
      wr(bws_pkg::OFS_STATUS_IO, 32'hffff_ffff);
      rd(bws_pkg::OFS_STATUS_IO, 32'h02a0_f1f1);
      wr(bws_pkg::OFS_MEM_WINDOW, 32'hffff_ffff);
      rd(bws_pkg::OFS_MEM_WINDOW, 32'hfff0_fff0);
      // Random windows, inverted ones included, with bound addresses
      repeat (6)
      begin
         fl = 4'($urandom);
         cl = 4'($urandom);
         mf = 12'($urandom % 16);
         mc = 12'($urandom % 16);
         wr(bws_pkg::OFS_STATUS_IO, {16'h0, cl, 4'h0, fl, 4'h0});
         wr(bws_pkg::OFS_MEM_WINDOW, {mc, 4'h0, mf, 4'h0});
         idle(1);
         for (int i = 0; i < 16; i++)
         begin
            io = i[0];
            case (i)
               0: ad = {mc, 20'hfffff};
               1: ad = {16'h0, cl, 12'hfff};
               2: ad = {mf, 20'h00000} - 32'h1;
               3: ad = {16'h0, fl, 12'h000};
               default: ad = $urandom & (io ? 32'h0001_ffff : 32'h00ff_ffff);
            endcase
            fwdQ.push_back(hitExp(io, ad));
            agent.txn(io, ad);
         end
         agent.idle();
      end
      idle(4);
      check("queues empty", 32'(rdQ.size() + fwdQ.size()), 32'h0);
      results();
   end
endmodule
